// File: rtl/exec_unit.sv
// Purpose: decode and run four accumulator instructions, four phases each
// Assumes: instruction words written over apb; file memory held locally
// Notes: one wait state on every apb access
`timescale 1ns/1ps
`include "exec_unit_regs.svh"

module exec_unit #(
  parameter int ADDR_W = 12 // data space address width
) (
  input wire logic pclk, // 10 MHz bus clock
  input wire logic presetn, // async reset, active low
  input wire exec_unit_pkg::apb_req_type apb_req, // apb request
  output exec_unit_pkg::apb_rsp_type apb_rsp, // apb response
  output logic busy, // instruction in progress
  output logic skip_taken // last instruction skipped
);
  import exec_unit_pkg::*;

  // one byte per data space address, four kilobytes at most
  localparam int MEM_DEPTH = 1 << ADDR_W;

  // file address must reach at least two 256-byte banks; the access bank
  // upper part, from 0x60 up, sits in the top bank, and bank select carries four bits only
  if (ADDR_W < 9 || ADDR_W > 12) begin : g_addr_w_check
    $error("ADDR_W must lie between 9 and 12");
  end

  logic [7:0] file_mem [MEM_DEPTH];
  state_type state_reg;
  decoded_type dec_reg;
  logic [15:0] instr_reg;
  logic two_word_next_reg;
  logic ext_en_reg;
  logic [7:0] acc_reg;
  logic [3:0] bank_sel_reg;
  logic [11:0] index_base_reg;
  logic [ADDR_W-1:0] mem_addr_reg;
  logic [ADDR_W-1:0] eff_addr_reg;
  logic [7:0] operand_reg;
  logic [7:0] result_reg;
  logic zero_reg;
  logic neg_reg;
  logic skip_reg;
  logic illegal_reg;
  logic [1:0] phase_reg;
  logic [1:0] nop_left_reg;
  logic [7:0] cycles_reg;
  logic [31:0] prdata_reg;
  logic pready_reg;
  logic pslverr_reg;

  // apb handshake terms; one wait state keeps prdata registered
  logic access;
  logic wr_fire;
  assign access = apb_req.psel && apb_req.penable && !pready_reg;
  // writes commit at the edge that completes the transfer, with pready high,
  // so a master that stretches its access phase never sees an early effect
  assign wr_fire = apb_req.psel && apb_req.penable && apb_req.pwrite && pready_reg;

  logic start;
  assign start = wr_fire && apb_req.paddr == `OFS_INSTR && state_reg == st_idle;

  // unknown words keep op_none: nothing written, illegal flag set
  // instruction decode, done from the latched word
  decoded_type dec_next;
  always_comb begin
    dec_next.op = op_none;
    dec_next.dest_file = instr_reg[9];
    dec_next.bank_bit = instr_reg[8];
    dec_next.operand = instr_reg[7:0];
    if (instr_reg[15:10] == `OPC_INC_SKIP_NZ) begin
      dec_next.op = op_inc_skip_if_nonzero;
    end else if (instr_reg[15:10] == `OPC_INC_SKIP_Z) begin
      dec_next.op = op_inc_skip_if_zero;
    end else if (instr_reg[15:10] == `OPC_OR_FILE) begin
      dec_next.op = op_or_acc_with_file;
    end else if (instr_reg[15:8] == `OPC_OR_LIT) begin
      dec_next.op = op_or_literal_into_acc;
      dec_next.dest_file = 1'b0;
    end
  end

  // effective file address from bank bit, bank select and index base
  logic [ADDR_W-1:0] eff_addr_next;
  logic [11:0] indexed_sum;
  assign indexed_sum = index_base_reg + {4'h0, dec_reg.operand};
  always_comb begin
    if (!dec_reg.bank_bit && ext_en_reg && dec_reg.operand <= `INDEXED_MAX) begin
      eff_addr_next = indexed_sum[ADDR_W-1:0];
    end else if (!dec_reg.bank_bit) begin
      // low part of access bank in bank 0, upper part in the top bank
      if (dec_reg.operand <= `INDEXED_MAX) begin
        eff_addr_next = {{(ADDR_W-8){1'b0}}, dec_reg.operand};
      end else begin
        eff_addr_next = {{(ADDR_W-8){1'b1}}, dec_reg.operand};
      end
    end else begin
      // bank select bits above the memory size are dropped
      eff_addr_next = ADDR_W'({bank_sel_reg, dec_reg.operand});
    end
  end

  // data processing for the q3 phase
  logic [7:0] result_next;
  always_comb begin
    case (dec_reg.op)
      op_inc_skip_if_zero, op_inc_skip_if_nonzero: result_next = operand_reg + 8'h01;
      op_or_literal_into_acc: result_next = acc_reg | dec_reg.operand;
      op_or_acc_with_file: result_next = acc_reg | operand_reg;
      default: result_next = 8'h00;
    endcase
  end

  // a two-word successor only stretches the skip, never changes its sense
  // skip decision from the processed result
  logic skip_now;
  assign skip_now = (dec_reg.op == op_inc_skip_if_nonzero && result_reg != 8'h00)
    || (dec_reg.op == op_inc_skip_if_zero && result_reg == 8'h00);

  logic is_or;
  assign is_or = dec_reg.op == op_or_literal_into_acc || dec_reg.op == op_or_acc_with_file;
  // the literal form always lands in the accumulator, whatever bit 9 holds
  logic acc_dest;
  assign acc_dest = dec_reg.op != op_none
    && (!dec_reg.dest_file || dec_reg.op == op_or_literal_into_acc);

  // phase sequencer; each instruction cycle is four pclk cycles
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= st_idle;
      phase_reg <= 2'd0;
      nop_left_reg <= 2'd0;
    end else begin
      case (state_reg)
        st_idle: begin
          if (start) begin
            state_reg <= st_q1;
          end
        end
        st_q1: state_reg <= st_q2;
        st_q2: state_reg <= st_q3;
        st_q3: state_reg <= st_q4;
        st_q4: begin
          phase_reg <= 2'd0;
          if (skip_now) begin
            state_reg <= st_nop;
            nop_left_reg <= two_word_next_reg ? 2'd2 : 2'd1;
          end else begin
            state_reg <= st_idle;
          end
        end
        st_nop: begin
          // each discarded word costs a full four-phase cycle
          phase_reg <= phase_reg + 2'd1;
          if (phase_reg == `PHASES_PER_CYCLE) begin
            nop_left_reg <= nop_left_reg - 2'd1;
            if (nop_left_reg == 2'd1) begin
              state_reg <= st_idle;
            end
          end
        end
        default: state_reg <= st_idle;
      endcase
    end
  end

  // decode in q1, read in q2, process in q3
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dec_reg <= '0;
      eff_addr_reg <= '0;
      operand_reg <= 8'h00;
      result_reg <= 8'h00;
    end else begin
      if (state_reg == st_q1) begin
        dec_reg <= dec_next;
      end
      if (state_reg == st_q2) begin
        eff_addr_reg <= eff_addr_next;
        operand_reg <= file_mem[eff_addr_next];
      end
      if (state_reg == st_q3) begin
        result_reg <= result_next;
      end
    end
  end

  // file memory; software writes are refused while an instruction runs
  always_ff @(posedge pclk) begin
    if (state_reg == st_q4 && dec_reg.dest_file && !is_or_lit(dec_reg.op)
        && dec_reg.op != op_none) begin
      file_mem[eff_addr_reg] <= result_reg;
    end else if (wr_fire && apb_req.paddr == `OFS_MEM_DATA && state_reg == st_idle) begin
      file_mem[mem_addr_reg] <= apb_req.pwdata[7:0];
    end
  end

  function automatic logic is_or_lit(input op_type op);
    is_or_lit = op == op_or_literal_into_acc;
  endfunction

  // accumulator; written by the q4 phase only, or by software when idle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_reg <= `ACC_RESET;
    end else if (state_reg == st_q4 && acc_dest) begin
      acc_reg <= result_reg;
    end else if (wr_fire && apb_req.paddr == `OFS_ACC && state_reg == st_idle) begin
      acc_reg <= apb_req.pwdata[7:0];
    end
  end

  // status flags; increments leave zero and negative alone
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      zero_reg <= 1'b0;
      neg_reg <= 1'b0;
      skip_reg <= 1'b0;
      illegal_reg <= 1'b0;
    end else if (state_reg == st_q4) begin
      skip_reg <= skip_now;
      illegal_reg <= dec_reg.op == op_none;
      if (is_or) begin
        neg_reg <= result_reg[7];
        zero_reg <= result_reg == 8'h00;
      end
    end
  end

  // counts q4 ends and finished no-operation cycles, so 1, 2 or 3
  // instruction cycles spent on the last instruction
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cycles_reg <= 8'h00;
    end else if (start) begin
      cycles_reg <= 8'h00;
    end else if (state_reg == st_q4
                 || (state_reg == st_nop && phase_reg == `PHASES_PER_CYCLE)) begin
      cycles_reg <= cycles_reg + 8'h01;
    end
  end

  // all refused while busy, so an instruction sees one consistent setup
  // software configuration registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_en_reg <= 1'b0;
      bank_sel_reg <= `BANK_SEL_RESET;
      index_base_reg <= `INDEX_BASE_RESET;
      mem_addr_reg <= '0;
      instr_reg <= 16'h0000;
      two_word_next_reg <= 1'b0;
    end else if (wr_fire && state_reg == st_idle) begin
      case (apb_req.paddr)
        `OFS_CTRL: ext_en_reg <= apb_req.pwdata[`CTRL_EXT_BIT];
        `OFS_BANK_SEL: bank_sel_reg <= apb_req.pwdata[3:0];
        `OFS_INDEX_BASE: index_base_reg <= apb_req.pwdata[11:0];
        `OFS_MEM_ADDR: mem_addr_reg <= apb_req.pwdata[ADDR_W-1:0];
        `OFS_INSTR: begin
          instr_reg <= apb_req.pwdata[15:0];
          two_word_next_reg <= apb_req.pwdata[`INSTR_TWO_WORD_BIT];
        end
        default: ;
      endcase
    end
  end

  // unmapped offsets read zero and raise pslverr
  // read mux
  logic [31:0] rd_data;
  logic decode_err;
  always_comb begin
    rd_data = 32'h0000_0000;
    decode_err = 1'b0;
    case (apb_req.paddr)
      `OFS_CTRL: rd_data[`CTRL_EXT_BIT] = ext_en_reg;
      `OFS_INSTR: rd_data = {15'h0000, two_word_next_reg, instr_reg};
      `OFS_ACC: rd_data[7:0] = acc_reg;
      `OFS_STATUS: begin
        rd_data[`ST_ZERO_BIT] = zero_reg;
        rd_data[`ST_NEG_BIT] = neg_reg;
        rd_data[`ST_BUSY_BIT] = state_reg != st_idle;
        rd_data[`ST_SKIP_BIT] = skip_reg;
        rd_data[`ST_ILLEGAL_BIT] = illegal_reg;
      end
      `OFS_BANK_SEL: rd_data[3:0] = bank_sel_reg;
      `OFS_INDEX_BASE: rd_data[11:0] = index_base_reg;
      `OFS_MEM_ADDR: rd_data[ADDR_W-1:0] = mem_addr_reg;
      `OFS_MEM_DATA: rd_data[7:0] = file_mem[mem_addr_reg];
      `OFS_CYCLES: rd_data[7:0] = cycles_reg;
      default: decode_err = 1'b1;
    endcase
  end

  // apb response, registered; ready one cycle into the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= 32'h0000_0000;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
    end else begin
      pready_reg <= access;
      pslverr_reg <= access && decode_err;
      if (access && !apb_req.pwrite) begin
        prdata_reg <= rd_data;
      end
    end
  end

  // busy drops in the edge the sequencer returns to idle, so an instruction
  // written in the very next transfer is never refused
  // status pins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy <= 1'b0;
      skip_taken <= 1'b0;
    end else begin
      busy <= (state_reg != st_idle || start) && !(state_reg == st_q4 && !skip_now)
        && !(state_reg == st_nop && phase_reg == `PHASES_PER_CYCLE && nop_left_reg == 2'd1);
      skip_taken <= state_reg == st_q4 ? skip_now : skip_reg;
    end
  end

  assign apb_rsp.prdata = prdata_reg;
  assign apb_rsp.pready = pready_reg;
  assign apb_rsp.pslverr = pslverr_reg;

endmodule

// File: rtl/exec_unit_regs.svh
// Purpose: register offsets, field positions, reset values and timing counts
// Assumes: 32-bit apb data, one aligned word per register
// Notes: definitions only
`ifndef EXEC_UNIT_REGS_SVH
`define EXEC_UNIT_REGS_SVH

// register byte offsets
`define OFS_CTRL 12'h000
`define OFS_INSTR 12'h004
`define OFS_ACC 12'h008
`define OFS_STATUS 12'h00c
`define OFS_BANK_SEL 12'h010
`define OFS_INDEX_BASE 12'h014
`define OFS_MEM_ADDR 12'h018
`define OFS_MEM_DATA 12'h01c
`define OFS_CYCLES 12'h020

// field positions
`define CTRL_EXT_BIT 0
`define INSTR_TWO_WORD_BIT 16
`define ST_ZERO_BIT 0
`define ST_NEG_BIT 1
`define ST_BUSY_BIT 2
`define ST_SKIP_BIT 3
`define ST_ILLEGAL_BIT 4

// reset values
`define ACC_RESET 8'h00
`define BANK_SEL_RESET 4'h0
`define INDEX_BASE_RESET 12'h000

// opcode patterns on instruction bits 15:10 (15:8 for the literal form)
`define OPC_INC_SKIP_NZ 6'h12
`define OPC_INC_SKIP_Z 6'h0f
`define OPC_OR_FILE 6'h04
`define OPC_OR_LIT 8'h09

// highest file address that uses indexed literal offset addressing
`define INDEXED_MAX 8'h5f

// last phase index of an instruction cycle, which has four phases
`define PHASES_PER_CYCLE 2'd3

`endif

// File: rtl/exec_unit_pkg.sv
// Purpose: shared types of the execution unit
// Assumes: constants come from exec_unit_regs.svh
// Notes: types only
package exec_unit_pkg;

  // gray codes along idle, q1..q4, then skip cycles
  typedef enum logic [2:0] {
    st_idle = 3'b000,
    st_q1 = 3'b001,
    st_q2 = 3'b011,
    st_q3 = 3'b010,
    st_q4 = 3'b110,
    st_nop = 3'b111
  } state_type;

  typedef enum logic [2:0] {
    op_none = 3'h0,
    op_inc_skip_if_zero = 3'h1,
    op_inc_skip_if_nonzero = 3'h2,
    op_or_literal_into_acc = 3'h3,
    op_or_acc_with_file = 3'h4
  } op_type;

  typedef struct packed {
    op_type op;
    logic dest_file;
    logic bank_bit;
    logic [7:0] operand;
  } decoded_type;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } apb_req_type;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } apb_rsp_type;

endpackage

// File: verification/exec_unit_checker.sv
// Purpose: port-level checks of the execution unit
// Assumes: one wait state on apb, busy covers whole instruction cycles
// Notes: bound to every exec_unit instance
`timescale 1ns/1ps
`include "exec_unit_regs.svh"
module exec_unit_checker (
  input wire logic pclk, // clock
  input wire logic presetn, // async reset, active low
  input wire exec_unit_pkg::apb_req_type apb_req, // apb request
  input wire exec_unit_pkg::apb_rsp_type apb_rsp, // apb response
  input wire logic busy, // instruction running
  input wire logic skip_taken // last instruction skipped
);
  import exec_unit_pkg::*;
  logic [4:0] run_reg;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // length of the busy span, judged once busy drops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) run_reg <= 5'h00;
    else if (busy) run_reg <= run_reg + 5'h01;
    else run_reg <= 5'h00;
  end
  property p_ready_pulse; apb_rsp.pready |=> !apb_rsp.pready; endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("pready held too long");
  property p_ready_answer; apb_req.psel && $rose(apb_req.penable) |=> apb_rsp.pready; endproperty
  a_ready_answer: assert property (p_ready_answer) else $error("pready not one cycle late");
  property p_ready_cause; apb_rsp.pready |-> $past(apb_req.psel && apb_req.penable); endproperty
  a_ready_cause: assert property (p_ready_cause) else $error("pready without access");
  property p_err_data; apb_rsp.pslverr |-> apb_rsp.pready && apb_rsp.prdata == 32'h0; endproperty
  a_err_data: assert property (p_err_data) else $error("bad error response");
  property p_start;
    apb_req.psel && apb_req.penable && apb_req.pwrite && apb_rsp.pready &&
      apb_req.paddr == `OFS_INSTR && !busy |=> busy;
  endproperty
  a_start: assert property (p_start) else $error("instruction did not start");
  property p_four_phase; $rose(busy) |-> busy[*4]; endproperty
  a_four_phase: assert property (p_four_phase) else $error("cycle shorter than four phases");
  property p_span; !busy && run_reg != 5'h00 |-> run_reg inside {5'd4, 5'd8, 5'd12}; endproperty
  a_span: assert property (p_span) else $error("busy span not whole cycles");
  property p_skip_span; !busy && run_reg != 5'h00 |-> skip_taken == (run_reg != 5'd4); endproperty
  a_skip_span: assert property (p_skip_span) else $error("skip flag and span disagree");
  // the skip flag moves only at the edge that ends the first instruction cycle
  property p_skip_hold; $changed(skip_taken) |-> $past(busy, 4) && !$past(busy, 5); endproperty
  a_skip_hold: assert property (p_skip_hold) else $error("skip flag moved mid run");
  // main scenarios reached
  c_two_word: cover property (!busy && run_reg == 5'd12);
  c_plain: cover property (!busy && run_reg == 5'd4);
  c_err: cover property (apb_rsp.pslverr);
endmodule
bind exec_unit exec_unit_checker exec_unit_checker_inst (.pclk(pclk), .presetn(presetn),
  .apb_req(apb_req), .apb_rsp(apb_rsp), .busy(busy), .skip_taken(skip_taken));

// File: verification/exec_unit_tb_top.sv
// Purpose: directed tests of the execution unit over apb
// Assumes: access bank below 0x60 maps to bank 0 with extension off, to index base plus offset with it on; above to the top bank
// Notes: one task per scenario
`timescale 1ns/1ps
`include "exec_unit_regs.svh"
module exec_unit_tb_top;
  import exec_unit_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  apb_req_type apb_req = '0;
  apb_rsp_type apb_rsp;
  logic busy;
  logic skip_taken;
  logic [31:0] rdata;
  logic slverr;
  int miscompares = 0;
  int comparisons = 0;
  exec_unit exec_unit_inst (.pclk(pclk), .presetn(presetn), .apb_req(apb_req),
    .apb_rsp(apb_rsp), .busy(busy), .skip_taken(skip_taken));
  // 10 mhz clock
  always #50 pclk = ~pclk;
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  // one transfer, held until pready is sampled high
  task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] wdata);
    int n;
    @(posedge pclk);
    apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: addr, pwdata: wdata};
    @(posedge pclk);
    apb_req.penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (apb_rsp.pready !== 1'b1 && n < 20);
    if (n == 20) miscompares++;
    rdata = apb_rsp.prdata;
    slverr = apb_rsp.pslverr;
    apb_req.psel <= 1'b0;
    apb_req.penable <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e, string w);
    apb(1'b0, a, 32'h0);
    chk(w, e, rdata & m);
  endtask
  task automatic mem_set(input logic [11:0] a, input logic [7:0] d);
    apb(1'b1, `OFS_MEM_ADDR, {20'h0, a});
    apb(1'b1, `OFS_MEM_DATA, {24'h0, d});
  endtask
  task automatic mem_rd(input logic [11:0] a, input logic [7:0] e);
    apb(1'b1, `OFS_MEM_ADDR, {20'h0, a});
    rd(`OFS_MEM_DATA, 32'hff, {24'h0, e}, "file byte");
  endtask
  // start an instruction, wait for busy to drop, then check the cycle count
  task automatic run(input logic [31:0] word, input logic [31:0] cyc);
    int n;
    apb(1'b1, `OFS_INSTR, word);
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (busy !== 1'b0 && n < 40);
    if (n == 40) miscompares++;
    rd(`OFS_CYCLES, 32'hff, cyc, "cycles");
  endtask
  task automatic t_or;
    apb(1'b1, `OFS_ACC, 32'h9a);
    run(32'h0935, 32'h1);
    rd(`OFS_ACC, 32'hff, 32'hbf, "acc");
    rd(`OFS_STATUS, 32'h3, 32'h2, "flags");
    mem_set(12'h013, 8'h13);
    apb(1'b1, `OFS_ACC, 32'h91);
    run(32'h1013, 32'h1);
    rd(`OFS_ACC, 32'hff, 32'h93, "acc");
    mem_rd(12'h013, 8'h13);
    apb(1'b1, `OFS_ACC, 32'h0);
    mem_set(12'h013, 8'h00);
    run(32'h1213, 32'h1);
    rd(`OFS_STATUS, 32'h3, 32'h1, "flags");
    $display("or tests done");
  endtask
  task automatic t_inc_nz;
    apb(1'b1, `OFS_BANK_SEL, 32'h2);
    mem_set(12'h240, 8'h05);
    run(32'h4b40, 32'h2);
    chk("skip_taken", 32'h1, {31'h0, skip_taken});
    mem_rd(12'h240, 8'h06);
    rd(`OFS_STATUS, 32'h8, 32'h8, "skip");
    run(32'h14b40, 32'h3);
    mem_rd(12'h240, 8'h07);
    mem_set(12'h240, 8'hff);
    run(32'h4b40, 32'h1);
    chk("skip_taken", 32'h0, {31'h0, skip_taken});
    $display("skip on nonzero done");
  endtask
  task automatic t_inc_z;
    logic [31:0] st;
    mem_set(12'h020, 8'hff);
    apb(1'b1, `OFS_ACC, 32'h55);
    apb(1'b0, `OFS_STATUS, 32'h0);
    st = rdata & 32'h3;
    chk("flags before", 32'h1, st);
    run(32'h3c20, 32'h2);
    rd(`OFS_ACC, 32'hff, 32'h00, "acc");
    rd(`OFS_STATUS, 32'h3, st, "flags");
    mem_rd(12'h020, 8'hff);
    mem_set(12'h020, 8'h01);
    run(32'h3c20, 32'h1);
    $display("skip on zero done");
  endtask
  task automatic t_indexed;
    apb(1'b1, `OFS_CTRL, 32'h1);
    apb(1'b1, `OFS_INDEX_BASE, 32'h300);
    mem_set(12'h35f, 8'h41);
    mem_set(12'hf60, 8'h07);
    run(32'h3e5f, 32'h1);
    mem_rd(12'h35f, 8'h42);
    run(32'h3e60, 32'h1);
    mem_rd(12'hf60, 8'h08);
    // unknown word: one plain cycle, illegal flag raised
    run(32'hffff, 32'h1);
    rd(`OFS_STATUS, 32'h10, 32'h10, "illegal");
    // accumulator write during the run is refused; q4 result stands
    apb(1'b1, `OFS_ACC, 32'h10);
    apb(1'b1, `OFS_INSTR, 32'h0901);
    apb(1'b1, `OFS_ACC, 32'h77);
    repeat (8) @(posedge pclk);
    rd(`OFS_ACC, 32'hff, 32'h11, "acc while busy");
    apb(1'b0, 12'hffc, 32'h0);
    chk("pslverr", 32'h1, {31'h0, slverr});
    $display("indexed and unmapped done");
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // main sequence after 16 cycles of reset
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    t_or();
    t_inc_nz();
    t_inc_z();
    t_indexed();
    tally_and_finish();
  end
  // watchdog, far beyond the few hundred cycles the tests need
  initial begin
    #2000000;
    miscompares++;
    tally_and_finish();
  end
endmodule
